// *** hw/plpi_engine.sv ***
// PHY-side low-power-idle policy engine for MACs without LPI signalling.
// Assumes one MAC block per MAC_VALID cycle and an APB master on the bus.
`timescale 1ns/1ps
`include "plpi_defines.svh"
module plpi_engine
  import plpi_pkg::*;
(
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_B,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    MAC_VALID,
  input  wire logic [`PLPI_CTRL_W-1:0] MAC_TXC,
  input  wire logic [`PLPI_DATA_W-1:0] MAC_TXD,
  output logic                         LINE_VALID,
  output logic      [`PLPI_CTRL_W-1:0] LINE_TXC,
  output logic      [`PLPI_DATA_W-1:0] LINE_TXD,
  output logic                         LINE_LPI,
  output logic                         LINE_WAKE,
  input  wire logic [1:0]              RATE_SEL,
  input  wire logic                    SERIAL_MAC_IF,
  input  wire logic                    LP_ADV_10G,
  output logic                         LOCAL_ADV_10G
);
  localparam logic [`PLPI_BLK_W-1:0] IDLE_BLK =
    {`PLPI_IDLE_CTRL, `PLPI_IDLE_DATA};
  localparam logic [`PLPI_BLK_W-1:0] LPI_BLK =
    {`PLPI_IDLE_CTRL, `PLPI_LPI_DATA};
  localparam logic [`PLPI_CNT_W-1:0] VAR_HOLD = 16'(`PLPI_VAR_BLOCKS);
  localparam logic [7:0]             TW_CYC   = 8'(`PLPI_TW_CYC);

  function automatic logic is_idle(input logic [`PLPI_BLK_W-1:0] blk);
    is_idle = (blk == IDLE_BLK);
  endfunction

  plpi_mode_t                 mode_ff;
  plpi_state_t                state_ff;
  plpi_state_t                nxt_state;
  logic [`PLPI_CNT_W-1:0]     thr_ff;
  logic [`PLPI_CNT_W-1:0]     lat_ff;
  logic [`PLPI_CNT_W-1:0]     idle_cnt_ff;
  logic [`PLPI_CNT_W-1:0]     nxt_idle_cnt;
  logic [`PLPI_CNT_W-1:0]     hold_cnt_ff;
  logic [`PLPI_CNT_W-1:0]     nxt_hold_cnt;
  logic [7:0]                 tw_cnt_ff;
  logic [15:0]                cmd_ff;
  logic [15:0]                status_ff;
  logic [15:0]                data1_ff;
  logic [15:0]                data2_ff;
  logic [15:0]                data3_ff;
  logic [15:0]                data4_ff;
  logic [31:0]                prdata_ff;
  logic                       line_valid_ff;
  logic [`PLPI_BLK_W-1:0]     line_blk_ff;
  logic [`PLPI_BLK_W-1:0]     nxt_line_blk;
  logic [`PLPI_BLK_W-1:0]     head;
  logic [`PLPI_FIFO_AW:0]     level;
  logic                       fifo_empty;
  logic                       fifo_full;

  // Bus decode.
  wire        wr_en     = PSEL && PENABLE && PWRITE;
  wire        rd_setup  = PSEL && !PENABLE && !PWRITE;
  wire        hit_cmd   = (PADDR == `PLPI_OFS_CMD);
  wire        hit_stat  = (PADDR == `PLPI_OFS_STATUS);
  wire        hit_d1    = (PADDR == `PLPI_OFS_DATA1);
  wire        hit_d2    = (PADDR == `PLPI_OFS_DATA2);
  wire        hit_d3    = (PADDR == `PLPI_OFS_DATA3);
  wire        hit_d4    = (PADDR == `PLPI_OFS_DATA4);
  wire        hit_adv   = (PADDR == `PLPI_OFS_LP_ADV);
  wire        hit_cap   = (PADDR == `PLPI_OFS_LOC_CAP);
  wire        hit_state = (PADDR == `PLPI_OFS_STATE);
  wire        mapped    = hit_cmd | hit_stat | hit_d1 | hit_d2 | hit_d3 |
                          hit_d4 | hit_adv | hit_cap | hit_state;
  wire        do_cmd    = wr_en && hit_cmd;
  wire        cmd_set   = do_cmd && (PWDATA[15:0] == `PLPI_CMD_SET);
  wire        cmd_get   = do_cmd && (PWDATA[15:0] == `PLPI_CMD_GET);

  // Managed modes are refused while a reduced rate rides the serial link.
  wire        rate_block = SERIAL_MAC_IF && (RATE_SEL != `PLPI_RATE_10G);
  wire        req_mgd    = (data1_ff[1:0] == PLPI_MODE_CONST) ||
                           (data1_ff[1:0] == PLPI_MODE_VAR);
  // A threshold not above the latency would sleep on buffered traffic.
  wire        set_bad    = req_mgd && (rate_block || data2_ff <= data3_ff);
  wire        mode_mgd   = (mode_ff == PLPI_MODE_CONST) ||
                           (mode_ff == PLPI_MODE_VAR);
  wire        managed    = mode_mgd && !rate_block;
  wire        is_var     = (mode_ff == PLPI_MODE_VAR);
  wire        apply      = cmd_set && !set_bad;
  wire        ready      = (mode_ff != PLPI_MODE_OFF) && LP_ADV_10G &&
                           (!mode_mgd || !rate_block);

  wire [`PLPI_BLK_W-1:0] in_blk  = {MAC_TXC, MAC_TXD};
  wire                   in_idle = MAC_VALID && is_idle(in_blk);
  wire                   in_data = MAC_VALID && !is_idle(in_blk);
  wire                   at_thr  = (idle_cnt_ff + 16'h0001 >= thr_ff);
  wire                   st_run  = (state_ff == PLPI_ST_RUN);
  wire                   st_lpi  = (state_ff == PLPI_ST_LPI);
  wire                   st_fill = (state_ff == PLPI_ST_FILL);
  wire                   st_wake = (state_ff == PLPI_ST_WAKE);
  // Variable latency drops idles while blocks wait, which shrinks the queue.
  wire                   var_push = in_data || (in_idle && st_run && fifo_empty);
  wire                   push = managed && !fifo_full && (is_var ? var_push :
                           MAC_VALID && (st_fill || st_run || st_lpi));
  wire                   pop  = managed && MAC_VALID && (st_run || st_lpi);
  wire                   lpi_out = st_lpi && in_idle;
  wire                   flush = apply || !managed;

  plpi_fifo u_fifo (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .flush (flush),
    .push  (push),
    .din   (in_blk),
    .pop   (pop),
    .dout  (head),
    .level (level),
    .empty (fifo_empty),
    .full  (fifo_full)
  );

  // Idle run length; any data block restarts it.
  always_comb begin
    nxt_idle_cnt = idle_cnt_ff;
    if (in_data) begin
      nxt_idle_cnt = '0;
    end else if (in_idle && !at_thr) begin
      nxt_idle_cnt = idle_cnt_ff + 16'h0001;
    end
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    if (!managed) begin
      nxt_state = PLPI_ST_THRU;
    end else begin
      case (state_ff)
        PLPI_ST_THRU: begin
          nxt_state = is_var ? PLPI_ST_RUN : PLPI_ST_FILL;
        end
        PLPI_ST_FILL: begin
          if (push && ({4'h0, level} + 16'h0001 >= lat_ff || fifo_full)) begin
            nxt_state = PLPI_ST_RUN;
          end
        end
        PLPI_ST_RUN: begin
          if (in_idle && at_thr) begin
            nxt_state = PLPI_ST_LPI;
          end
        end
        PLPI_ST_LPI: begin
          if (in_data) begin
            nxt_state    = is_var ? PLPI_ST_WAKE : PLPI_ST_RUN;
            nxt_hold_cnt = VAR_HOLD;
          end
        end
        PLPI_ST_WAKE: begin
          if (MAC_VALID) begin
            nxt_hold_cnt = hold_cnt_ff - 16'h0001;
            // The last held cycle is the 700th, so the wake wait is exact.
            if (hold_cnt_ff <= 16'h0001) begin
              nxt_state = PLPI_ST_RUN;
            end
          end
        end
        default: begin
          nxt_state = PLPI_ST_THRU;
        end
      endcase
    end
  end

  // Line block choice; the FIFO head is only sent when it is popped.
  always_comb begin
    if (!managed) begin
      nxt_line_blk = in_blk;
    end else if (lpi_out) begin
      nxt_line_blk = LPI_BLK;
    end else if (pop && !fifo_empty) begin
      nxt_line_blk = head;
    end else begin
      nxt_line_blk = IDLE_BLK;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff      <= PLPI_ST_THRU;
      idle_cnt_ff   <= '0;
      hold_cnt_ff   <= '0;
      line_valid_ff <= 1'b0;
      line_blk_ff   <= IDLE_BLK;
    end else begin
      state_ff      <= flush ? PLPI_ST_THRU : nxt_state;
      idle_cnt_ff   <= flush ? '0 : nxt_idle_cnt;
      hold_cnt_ff   <= nxt_hold_cnt;
      line_valid_ff <= MAC_VALID;
      line_blk_ff   <= MAC_VALID ? nxt_line_blk : line_blk_ff;
    end
  end

  // Wake recovery window after the line leaves low-power output.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      tw_cnt_ff <= '0;
    end else if (st_lpi && in_data) begin
      tw_cnt_ff <= TW_CYC;
    end else if (tw_cnt_ff != '0) begin
      tw_cnt_ff <= tw_cnt_ff - 8'h01;
    end
  end

  // Command handler and register writes.
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ff   <= PLPI_MODE_OFF;
      thr_ff    <= `PLPI_THR_RESET;
      lat_ff    <= `PLPI_LAT_RESET;
      cmd_ff    <= '0;
      status_ff <= '0;
      data1_ff  <= '0;
      data2_ff  <= '0;
      data3_ff  <= '0;
      data4_ff  <= '0;
    end else if (wr_en) begin
      if (hit_cmd) begin
        cmd_ff    <= PWDATA[15:0];
        status_ff <= (apply || cmd_get) ? `PLPI_ST_PASS : `PLPI_ST_ERROR;
      end
      if (apply) begin
        mode_ff <= plpi_mode_t'(data1_ff[1:0]);
        thr_ff  <= data2_ff;
        lat_ff  <= data3_ff;
      end
      if (cmd_get) begin
        data2_ff <= {15'h0000, ready};
        data3_ff <= thr_ff;
        data4_ff <= lat_ff;
      end
      if (hit_stat) begin
        status_ff <= PWDATA[15:0];
      end
      if (hit_d1) begin
        data1_ff <= PWDATA[15:0];
      end
      if (hit_d2) begin
        data2_ff <= PWDATA[15:0];
      end
      if (hit_d3) begin
        data3_ff <= PWDATA[15:0];
      end
      if (hit_d4) begin
        data4_ff <= PWDATA[15:0];
      end
    end
  end

  // Read data is captured in the setup cycle and shown in the access cycle.
  wire [31:0] rd_mux =
    hit_cmd   ? {16'h0000, cmd_ff} :
    hit_stat  ? {16'h0000, status_ff} :
    hit_d1    ? {16'h0000, data1_ff} :
    hit_d2    ? {16'h0000, data2_ff} :
    hit_d3    ? {16'h0000, data3_ff} :
    hit_d4    ? {16'h0000, data4_ff} :
    hit_adv   ? (32'h0000_0000 | ({31'h0, LP_ADV_10G} << `PLPI_ADV_BIT)) :
    hit_cap   ? (32'h0000_0001 << `PLPI_ADV_BIT) :
    hit_state ? {4'h0, level, 9'h000, tw_cnt_ff != '0, st_wake,
                 st_lpi, st_fill, managed, mode_ff} :
    32'h0000_0000;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      prdata_ff <= '0;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

  assign PRDATA        = prdata_ff;
  assign PREADY        = 1'b1;
  assign PSLVERR       = PSEL && PENABLE && !mapped;
  assign LINE_VALID    = line_valid_ff;
  assign LINE_TXC      = line_blk_ff[`PLPI_BLK_W-1:`PLPI_DATA_W];
  assign LINE_TXD      = line_blk_ff[`PLPI_DATA_W-1:0];
  assign LINE_LPI      = (line_blk_ff == LPI_BLK);
  assign LINE_WAKE     = (tw_cnt_ff != '0);
  assign LOCAL_ADV_10G = (mode_ff != PLPI_MODE_OFF);
endmodule

// *** pkg/plpi_defines.svh ***
// Constants of the PHY-managed low-power-idle policy engine.
// Assumes a 10 MHz core clock and 32-bit APB register access.
// Notes on behaviour
// - Enter low-power output at idle threshold
// - Any non-idle block ends low-power output
// - No managed mode at 2.5G/5G over serial
// - Counts in 72-bit blocks, frame is 50
// - Fill FIFO to latency, then stream through
// - Default constant latency is 23 frames
// - Low-power blocks replace buffered idles
// - Non-idle resumes sending buffered idles
// - Variable mode wakes after 14 to 23 frames
// - Variable mode uses user idle threshold
// - Off at reset, changed only by command
// - Applied mode is advertised to partner
// - Report partner advertisement and local capability bit 3
// - Get command returns readiness, threshold, latency
// - Wake recovery lasts at most 4.48 us
`ifndef PLPI_DEFINES_SVH
`define PLPI_DEFINES_SVH

`define PLPI_CTRL_W        8
`define PLPI_DATA_W        64
`define PLPI_BLK_W         72
`define PLPI_FIFO_AW       11
`define PLPI_CNT_W         16
`define PLPI_FRAME_BLOCKS  50
`define PLPI_CL_FRAMES     23
`define PLPI_VAR_FRAMES    14
`define PLPI_CL_BLOCKS     (`PLPI_CL_FRAMES * `PLPI_FRAME_BLOCKS)
`define PLPI_VAR_BLOCKS    (`PLPI_VAR_FRAMES * `PLPI_FRAME_BLOCKS)
`define PLPI_THR_RESET     16'h047F
`define PLPI_LAT_RESET     16'h047E

`define PLPI_CLK_NS        100
`define PLPI_TW_NS         4480
`define PLPI_TW_CYC        (`PLPI_TW_NS / `PLPI_CLK_NS)

`define PLPI_IDLE_CTRL     8'hFF
`define PLPI_IDLE_DATA     64'h0707070707070707
`define PLPI_LPI_DATA      64'h0606060606060606

`define PLPI_RATE_10G      2'h0
`define PLPI_ADV_BIT       3

`define PLPI_CMD_GET       16'h8008
`define PLPI_CMD_SET       16'h8009
`define PLPI_ST_PASS       16'h0004
`define PLPI_ST_ERROR      16'h0008

`define PLPI_OFS_CMD       12'h000
`define PLPI_OFS_STATUS    12'h004
`define PLPI_OFS_DATA1     12'h008
`define PLPI_OFS_DATA2     12'h00C
`define PLPI_OFS_DATA3     12'h010
`define PLPI_OFS_DATA4     12'h014
`define PLPI_OFS_LP_ADV    12'h018
`define PLPI_OFS_LOC_CAP   12'h01C
`define PLPI_OFS_STATE     12'h020

`endif

// *** pkg/plpi_pkg.sv ***
// Types of the PHY-managed low-power-idle policy engine.
// Assumes nothing beyond a SystemVerilog compiler.
package plpi_pkg;

  typedef enum logic [1:0] {
    PLPI_MODE_OFF,
    PLPI_MODE_IEEE,
    PLPI_MODE_CONST,
    PLPI_MODE_VAR
  } plpi_mode_t;

  typedef enum logic [2:0] {
    PLPI_ST_THRU,
    PLPI_ST_FILL,
    PLPI_ST_RUN,
    PLPI_ST_LPI,
    PLPI_ST_WAKE
  } plpi_state_t;

endpackage

// *** hw/plpi_fifo.sv ***
// Block FIFO that holds MAC blocks while the line may be asleep.
// Assumes push is never given when full; pop may meet a same-cycle push.
`timescale 1ns/1ps
`include "plpi_defines.svh"
module plpi_fifo
  import plpi_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        flush,
  input  wire logic                        push,
  input  wire logic [`PLPI_BLK_W-1:0]      din,
  input  wire logic                        pop,
  output logic      [`PLPI_BLK_W-1:0]      dout,
  output logic      [`PLPI_FIFO_AW:0]      level,
  output logic                             empty,
  output logic                             full
);
  logic [`PLPI_BLK_W-1:0]   mem [0:(1<<`PLPI_FIFO_AW)-1];
  logic [`PLPI_FIFO_AW-1:0] wr_ptr_ff;
  logic [`PLPI_FIFO_AW-1:0] rd_ptr_ff;
  logic [`PLPI_FIFO_AW:0]   level_ff;
  wire                      do_push = push && !full;
  wire                      do_pop  = pop && !empty;

  assign dout  = mem[rd_ptr_ff];
  assign level = level_ff;
  assign empty = (level_ff == '0);
  assign full  = level_ff[`PLPI_FIFO_AW];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= din;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      level_ff  <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + {{(`PLPI_FIFO_AW-1){1'b0}}, do_push};
      rd_ptr_ff <= rd_ptr_ff + {{(`PLPI_FIFO_AW-1){1'b0}}, do_pop};
      level_ff  <= level_ff + {{`PLPI_FIFO_AW{1'b0}}, do_push}
                            - {{`PLPI_FIFO_AW{1'b0}}, do_pop};
    end
  end
endmodule

// *** dv/plpi_asserts.sv ***
// Port checker for the low-power-idle policy engine.
// Assumes it is bound to plpi_engine and sees only its ports.
`timescale 1ns/1ps
`include "plpi_defines.svh"
module plpi_asserts (
  input wire logic        CORE_CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        MAC_VALID,
  input wire logic [7:0]  MAC_TXC,
  input wire logic [63:0] MAC_TXD,
  input wire logic        LINE_VALID,
  input wire logic [7:0]  LINE_TXC,
  input wire logic [63:0] LINE_TXD,
  input wire logic        LINE_LPI,
  input wire logic        LINE_WAKE,
  input wire logic        LOCAL_ADV_10G
);
  logic [6:0] wake_cnt_ff;
  logic [6:0] nxt_wake_cnt;
  wire logic  idle_in;
  wire logic  cmd_wr;
  assign idle_in = MAC_VALID && MAC_TXC == `PLPI_IDLE_CTRL
                   && MAC_TXD == `PLPI_IDLE_DATA;
  assign cmd_wr = PSEL && PENABLE && PWRITE && PADDR == `PLPI_OFS_CMD;
  // Counts the wake pulse so its full length can be judged when it ends.
  assign nxt_wake_cnt = LINE_WAKE ? wake_cnt_ff + 7'h01 : 7'h00;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) wake_cnt_ff <= 7'h00;
    else wake_cnt_ff <= nxt_wake_cnt;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_data_in_lpi;
    LINE_LPI && MAC_VALID && !idle_in;
  endsequence
  sequence s_wake_exit;
    !LINE_LPI && LINE_WAKE;
  endsequence
  a_lpi_after_idle: assert property ($rose(LINE_LPI) |-> $past(idle_in))
    else $error("low-power output began without an idle input");
  a_data_ends_lpi: assert property (s_data_in_lpi |=> s_wake_exit)
    else $error("data block did not end low-power output");
  a_lpi_block_code: assert property (LINE_LPI |->
    LINE_TXC == `PLPI_IDLE_CTRL && LINE_TXD == `PLPI_LPI_DATA)
    else $error("low-power block has the wrong code");
  a_wake_length: assert property ($fell(LINE_WAKE) |->
    wake_cnt_ff == `PLPI_TW_CYC) else $error("wake pulse length wrong");
  a_wake_from_lpi: assert property ($rose(LINE_WAKE) |-> $fell(LINE_LPI))
    else $error("wake began outside a low-power exit");
  a_valid_copy: assert property (LINE_VALID == $past(MAC_VALID))
    else $error("line valid is not the delayed input valid");
  a_pass_thru: assert property (!LOCAL_ADV_10G && $past(!LOCAL_ADV_10G)
    && $past(MAC_VALID) |-> LINE_TXC == $past(MAC_TXC)
    && LINE_TXD == $past(MAC_TXD)) else $error("pass-through block wrong");
  a_adv_by_cmd: assert property ($changed(LOCAL_ADV_10G) |->
    $past(cmd_wr) || $past(cmd_wr, 2)) else $error("advert moved alone");
  a_apb_answer: assert property (PSEL && PENABLE |-> PREADY &&
    PSLVERR == (PADDR > `PLPI_OFS_STATE)) else $error("bus answer wrong");
endmodule
bind plpi_engine plpi_asserts u_plpi_asserts (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .MAC_VALID(MAC_VALID), .MAC_TXC(MAC_TXC), .MAC_TXD(MAC_TXD),
  .LINE_VALID(LINE_VALID), .LINE_TXC(LINE_TXC), .LINE_TXD(LINE_TXD),
  .LINE_LPI(LINE_LPI), .LINE_WAKE(LINE_WAKE),
  .LOCAL_ADV_10G(LOCAL_ADV_10G));

// *** dv/plpi_mac_model.sv ***
// Legacy MAC model: streams idle blocks, or a numbered data block on ask.
// Assumes the bench raises send_data for one cycle per data block.
`timescale 1ns/1ps
`include "plpi_defines.svh"
module plpi_mac_model (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    send_data,
  output logic                         valid_ff,
  output logic      [`PLPI_CTRL_W-1:0] txc_ff,
  output logic      [`PLPI_DATA_W-1:0] txd_ff
);
  logic [15:0] seq_ff;
  // This MAC has no low-power signalling, so between data it only idles.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_ff <= 1'b0;
      txc_ff   <= `PLPI_IDLE_CTRL;
      txd_ff   <= `PLPI_IDLE_DATA;
      seq_ff   <= 16'h0000;
    end else begin
      valid_ff <= 1'b1;
      txc_ff   <= send_data ? 8'h00 : `PLPI_IDLE_CTRL;
      txd_ff   <= send_data ? {48'hD0D0D0D0D0D0, seq_ff} : `PLPI_IDLE_DATA;
      seq_ff   <= seq_ff + {15'h0000, send_data};
    end
  end
endmodule

// *** dv/plpi_engine_test.sv ***
// Self-checking bench for the low-power-idle policy engine.
// Assumes the legacy MAC model on the stream side and APB access.
`timescale 1ns/1ps
`include "plpi_defines.svh"
module plpi_engine_test;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mac_valid;
  logic [7:0]  mac_txc;
  logic [63:0] mac_txd;
  logic        line_lpi;
  logic [7:0]  line_txc;
  logic [1:0]  rate_sel = 2'h0;
  logic        serial_mac_if = 1'b0;
  logic        lp_adv = 1'b1;
  logic        local_adv;
  logic        send_data = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0;
  int          n_compared = 0;
  int          n;
  int          cnt;
  always #50 clk = ~clk;
  plpi_mac_model u_plpi_mac_model (.clk(clk), .rst_b(rst_b),
    .send_data(send_data), .valid_ff(mac_valid), .txc_ff(mac_txc),
    .txd_ff(mac_txd));
  plpi_engine u_plpi_engine (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MAC_VALID(mac_valid), .MAC_TXC(mac_txc), .MAC_TXD(mac_txd),
    .LINE_VALID(), .LINE_TXC(line_txc), .LINE_TXD(), .LINE_LPI(line_lpi),
    .LINE_WAKE(), .RATE_SEL(rate_sel), .SERIAL_MAC_IF(serial_mac_if),
    .LP_ADV_10G(lp_adv), .LOCAL_ADV_10G(local_adv));
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("bus answer", 1, i < 20);
    if (i >= 20) finish_test();
  endtask
  task set_mode(input logic [31:0] m, thr, lat, input logic ser,
                input logic [1:0] rt, input logic [31:0] st);
    @(posedge clk);
    serial_mac_if <= ser;
    rate_sel <= rt;
    apb(1'b1, `PLPI_OFS_DATA1, m);
    apb(1'b1, `PLPI_OFS_DATA2, thr);
    apb(1'b1, `PLPI_OFS_DATA3, lat);
    apb(1'b1, `PLPI_OFS_CMD, `PLPI_CMD_SET);
    apb(1'b0, `PLPI_OFS_STATUS, 0);
    chk("set status", st, rd);
  endtask
  task get_chk(input logic rdy);
    apb(1'b1, `PLPI_OFS_CMD, `PLPI_CMD_GET);
    apb(1'b0, `PLPI_OFS_DATA2, 0);
    chk("readiness", rdy, rd);
    apb(1'b0, `PLPI_OFS_DATA3, 0);
    chk("threshold", 1151, rd);
    apb(1'b0, `PLPI_OFS_DATA4, 0);
    chk("latency", 1150, rd);
  endtask
  task wait_on(input logic lpi, input int lim);
    n = 0;
    while (n < lim && (lpi ? line_lpi !== 1'b1 : line_txc !== 8'h00)) begin
      @(posedge clk);
      n++;
    end
    chk("awaited event", 1, n < lim);
    if (n >= lim) finish_test();
  endtask
  task pulse();
    @(posedge clk);
    send_data <= 1'b1;
    @(posedge clk);
    send_data <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("advert after reset", 0, local_adv);
    apb(1'b0, `PLPI_OFS_LOC_CAP, 0);
    chk("local capability", 32'h8, rd);
    apb(1'b0, `PLPI_OFS_LP_ADV, 0);
    chk("partner advert", 32'h8, rd);
    apb(1'b0, 12'h040, 0);
    chk("unmapped error", 1, er);
    chk("unmapped data", 0, rd);
    // Threshold and latency are kept legal except where refusal is wanted.
    set_mode(2, 1150, 1150, 1'b0, 2'h0, `PLPI_ST_ERROR);
    set_mode(2, 1151, 1150, 1'b1, 2'h1, `PLPI_ST_ERROR);
    set_mode(3, 1151, 1150, 1'b1, 2'h2, `PLPI_ST_ERROR);
    chk("advert after refusal", 0, local_adv);
    set_mode(1, 1151, 1150, 1'b1, 2'h0, `PLPI_ST_PASS);
    chk("advert ieee", 1, local_adv);
    apb(1'b1, `PLPI_OFS_CMD, 32'h8000);
    apb(1'b0, `PLPI_OFS_STATUS, 0);
    chk("unknown command", `PLPI_ST_ERROR, rd);
    set_mode(2, 1151, 1150, 1'b0, 2'h0, `PLPI_ST_PASS);
    get_chk(1'b1);
    wait_on(1'b1, 4000);
    pulse();
    wait_on(1'b0, 3000);
    chk("constant delay", 1, n >= 1148 && n <= 1156);
    // The idle run is already near threshold here, so only a cleared
    // counter keeps the line awake through the next window.
    pulse();
    @(posedge clk);
    cnt = 0;
    repeat (1100) begin
      @(posedge clk);
      if (line_lpi !== 1'b0) cnt++;
    end
    chk("short idle run", 0, cnt);
    set_mode(3, 1151, 1150, 1'b0, 2'h0, `PLPI_ST_PASS);
    wait_on(1'b1, 4000);
    pulse();
    wait_on(1'b0, 3000);
    chk("variable delay", 1, n >= 700 && n <= 1160);
    set_mode(0, 1151, 1150, 1'b0, 2'h0, `PLPI_ST_PASS);
    get_chk(1'b0);
    chk("advert off", 0, local_adv);
    finish_test();
  end
endmodule
